// File: tcie_defs.svh
// Register offsets, field positions, reset values and masks of the channel interrupt enables
`ifndef TCIE_DEFS_SVH
`define TCIE_DEFS_SVH

// ==================================================
// Geometry
`define TCIE_NUM_CH 6
`define TCIE_ADDR_W 8
`define TCIE_DATA_W 8
`define TCIE_CNT_W 16

// ==================================================
// Register offsets
`define TCIE_OFS_ENABLE_BASE 8'h00
`define TCIE_OFS_STATUS_BASE 8'h08
`define TCIE_OFS_SUM_STATUS 8'h10
`define TCIE_OFS_SUM_MASK 8'h11

// ==================================================
// Enable register fields
`define TCIE_BIT_CONV_TRIG 7
`define TCIE_BIT_RSVD_ONE 6
`define TCIE_BIT_UNDERFLOW 5
`define TCIE_BIT_OVERFLOW 4
`define TCIE_BIT_EVENT_D 3
`define TCIE_BIT_EVENT_C 2
`define TCIE_BIT_EVENT_B 1
`define TCIE_BIT_EVENT_A 0

// Status register count direction bit
`define TCIE_BIT_COUNT_DIR 7

// ==================================================
// Reset values and writable masks
`define TCIE_ENABLE_RESET 8'h40
`define TCIE_RSVD_ONES 8'h40
`define TCIE_ENABLE_WMASK_CD 8'h9f
`define TCIE_ENABLE_WMASK_UF 8'hb3
`define TCIE_FLAG_MASK_CD 6'h1f
`define TCIE_FLAG_MASK_UF 6'h33
`define TCIE_CNT_MAX 16'hffff
`define TCIE_CNT_ZERO 16'h0000

`endif

// File: tcie_irq_enable.sv
// Six-channel timer interrupt enable gating with status flags and summary interrupt
`timescale 1ns/1ns
`default_nettype none
`include "tcie_defs.svh"

// Function
// - Each of the six channels has its own enable register that steers only that channel.
// - Bit 7 passes or blocks the converter start trigger caused by an event A.
// - Bit 6 is reserved, always reads 1 and ignores writes.
// - In channels 1, 2, 4 and 5 bit 5 gates the underflow request from the underflow flag.
// - In channels 0 and 3 bit 5 reads 0, cannot be written and no underflow request exists.
// - In every channel bit 4 gates the overflow request from the overflow flag.
// - In channels 0 and 3 bit 3 gates the event D request from the D flag.
// - In channels 0 and 3 bit 2 gates the event C request from the C flag.
// - In channels 1, 2, 4 and 5 bits 3 and 2 read 0, cannot be written, and give no request.
// - In every channel bit 1 gates the event B request from the B flag.
// - In every channel bit 0 gates the event A request from the A flag.
// - The overflow flag sets when the counter wraps from its maximum to zero.
// - The underflow flag sets when the counter wraps from zero to maximum in phase counting.
module tcie_irq_enable (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	input wire tcie_pkg::tcie_chan_in_t [5:0] chan_in,
	output tcie_pkg::tcie_chan_req_t [5:0] chan_req,
	output logic irq
);
	import tcie_pkg::*;

	// ==================================================
	// Storage
	logic [7:0] timer_irq_enable [0:5];
	logic [5:0] timer_status [0:5];
	logic [5:0] clear_armed [0:5];
	logic [15:0] prev_count [0:5];
	logic [5:0] prev_valid;
	logic [5:0] conv_pulse;
	logic [5:0] req_any;
	logic [5:0] req_any_prev;
	logic [5:0] sum_status;
	logic [5:0] sum_mask;
	logic [7:0] next_rdata;

	// ==================================================
	// Address decode
	wire [4:0] enable_base = 5'(`TCIE_OFS_ENABLE_BASE >> 3);
	wire [4:0] status_base = 5'(`TCIE_OFS_STATUS_BASE >> 3);
	wire in_enable_grp = (reg_addr[7:3] == enable_base) && (reg_addr[2:0] < 3'h6);
	wire in_status_grp = (reg_addr[7:3] == status_base) && (reg_addr[2:0] < 3'h6);
	wire hit_sum_status = (reg_addr == `TCIE_OFS_SUM_STATUS);
	wire hit_sum_mask = (reg_addr == `TCIE_OFS_SUM_MASK);
	wire [2:0] sel_ch = reg_addr[2:0];

	// ==================================================
	// Per-channel logic
	genvar ch;
	generate
		for (ch = 0; ch < `TCIE_NUM_CH; ch = ch + 1) begin : g_ch
			// Channels 0 and 3 own C/D, the others own underflow
			localparam bit HAS_CD = (ch == 0) || (ch == 3);
			localparam logic [7:0] EN_WMASK = HAS_CD ? `TCIE_ENABLE_WMASK_CD : `TCIE_ENABLE_WMASK_UF;
			localparam logic [5:0] FLAG_MASK = HAS_CD ? `TCIE_FLAG_MASK_CD : `TCIE_FLAG_MASK_UF;

			wire en_wr = reg_write && in_enable_grp && (sel_ch == 3'(ch));
			wire st_wr = reg_write && in_status_grp && (sel_ch == 3'(ch));
			wire st_rd = reg_read && in_status_grp && (sel_ch == 3'(ch));

			// Counter wrap detection
			wire ovf_evt = prev_valid[ch] && (prev_count[ch] == `TCIE_CNT_MAX)
				&& (chan_in[ch].count == `TCIE_CNT_ZERO);
			wire unf_evt = prev_valid[ch] && chan_in[ch].phase_mode
				&& (prev_count[ch] == `TCIE_CNT_ZERO)
				&& (chan_in[ch].count == `TCIE_CNT_MAX);

			// Flag set vector in status layout, reserved flags never set
			wire [5:0] flag_set = {unf_evt, ovf_evt, chan_in[ch].match_d, chan_in[ch].match_c,
				chan_in[ch].match_b, chan_in[ch].match_a} & FLAG_MASK;

			// Clear only bits written 0 that were read as 1 before
			wire [5:0] flag_clr = st_wr ? (~reg_wdata[5:0] & clear_armed[ch]) : 6'h00;

			// Request gating: flag AND enable, layouts match bit for bit
			wire [5:0] gated = timer_status[ch] & timer_irq_enable[ch][5:0];

			// Enable register, reserved bits held at fixed values
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					timer_irq_enable[ch] <= `TCIE_ENABLE_RESET;
				end else if (en_wr) begin
					timer_irq_enable[ch] <= (reg_wdata & EN_WMASK) | `TCIE_RSVD_ONES;
				end
			end

			// Status flags, a set in the clearing cycle wins
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					timer_status[ch] <= 6'h00;
				end else begin
					timer_status[ch] <= (timer_status[ch] & ~flag_clr) | flag_set;
				end
			end

			// Arm clearing when software reads a flag as 1
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					clear_armed[ch] <= 6'h00;
				end else if (st_rd) begin
					clear_armed[ch] <= timer_status[ch];
				end else begin
					clear_armed[ch] <= clear_armed[ch] & ~flag_clr;
				end
			end

			// Previous counter value for wrap detection
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					prev_count[ch] <= 16'h0000;
					prev_valid[ch] <= 1'b0;
				end else begin
					prev_count[ch] <= chan_in[ch].count;
					prev_valid[ch] <= 1'b1;
				end
			end

			// Converter trigger from event A, gated by its enable
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					conv_pulse[ch] <= 1'b0;
				end else begin
					conv_pulse[ch] <= chan_in[ch].match_a
						&& timer_irq_enable[ch][`TCIE_BIT_CONV_TRIG];
				end
			end

			// Request outputs
			assign chan_req[ch].conv_trigger = conv_pulse[ch];
			assign chan_req[ch].underflow_irq = gated[`TCIE_BIT_UNDERFLOW];
			assign chan_req[ch].overflow_irq = gated[`TCIE_BIT_OVERFLOW];
			assign chan_req[ch].event_d_irq = gated[`TCIE_BIT_EVENT_D];
			assign chan_req[ch].event_c_irq = gated[`TCIE_BIT_EVENT_C];
			assign chan_req[ch].event_b_irq = gated[`TCIE_BIT_EVENT_B];
			assign chan_req[ch].event_a_irq = gated[`TCIE_BIT_EVENT_A];
			assign req_any[ch] = |gated;
		end
	endgenerate

	// ==================================================
	// Summary interrupt
	wire sum_rd = reg_read && hit_sum_status;
	wire [5:0] sum_set = req_any & ~req_any_prev;

	// Edge history of per-channel requests
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			req_any_prev <= 6'h00;
		end else begin
			req_any_prev <= req_any;
		end
	end

	// Sticky summary, read clears, new set wins
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sum_status <= 6'h00;
		end else begin
			sum_status <= (sum_rd ? 6'h00 : sum_status) | sum_set;
		end
	end

	// Summary mask
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sum_mask <= 6'h00;
		end else if (reg_write && hit_sum_mask) begin
			sum_mask <= reg_wdata[5:0];
		end
	end

	assign irq = |(sum_status & sum_mask);

	// ==================================================
	// Read path
	always_comb begin
		next_rdata = 8'h00;
		if (in_enable_grp) begin
			next_rdata = timer_irq_enable[sel_ch];
		end else if (in_status_grp) begin
			next_rdata = {1'b1, 1'b1, timer_status[sel_ch]};
			if ((sel_ch != 3'h0) && (sel_ch != 3'h3)) begin
				next_rdata[`TCIE_BIT_COUNT_DIR] = chan_in[sel_ch].count_up;
			end
		end else if (hit_sum_status) begin
			next_rdata = {2'b00, sum_status};
		end else if (hit_sum_mask) begin
			next_rdata = {2'b00, sum_mask};
		end
	end

	// Read data one cycle after the strobe, zero otherwise
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_read ? next_rdata : 8'h00;
		end
	end

endmodule
`default_nettype wire

// File: tcie_irq_enable_assertions.sv
// Concurrent checks on the channel interrupt enable ports
`timescale 1ns/1ns
`default_nettype none
module tcie_chk (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata,
	input wire tcie_pkg::tcie_chan_in_t [5:0] chan_in,
	input wire tcie_pkg::tcie_chan_req_t [5:0] chan_req,
	input wire logic irq
);
	import tcie_pkg::*;
	// ====
	// Request and register checks
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	trig_cause_a: assert property (chan_req[0].conv_trigger |-> $past(chan_in[0].match_a))
		else $error("trigger without event a");
	no_uf_req_a: assert property (!(chan_req[0].underflow_irq || chan_req[3].underflow_irq))
		else $error("underflow request on channel 0 or 3");
	no_cd_req_a: assert property (!(chan_req[1].event_c_irq || chan_req[1].event_d_irq))
		else $error("event c or d request on channel 1");
	rsvd_one_a: assert property (reg_read && reg_addr < 8'h06 |=> reg_rdata[6])
		else $error("reserved enable bit reads 0");
	uf_bit_zero_a: assert property (reg_read && reg_addr == 8'h00 |=> !reg_rdata[5])
		else $error("channel 0 bit 5 reads 1");
	evt_a_rise_a: assert property ($rose(chan_req[0].event_a_irq)
		|-> $past(chan_in[0].match_a || reg_write)) else $error("event a request without cause");
	ovf_rise_a: assert property ($rose(chan_req[2].overflow_irq) |-> $past(reg_write)
		|| ($past(chan_in[2].count, 2) == 16'hffff && $past(chan_in[2].count) == 16'h0000))
		else $error("overflow request without wrap");
	ovf_drop_a: assert property ($fell(chan_req[2].overflow_irq) |-> $past(reg_write))
		else $error("overflow request dropped without write");
	// Main scenarios
	cover property (chan_req[0].conv_trigger);
	cover property (irq);
	cover property ($fell(chan_req[2].overflow_irq));
endmodule
bind tcie_irq_enable tcie_chk i_tcie_chk (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_write,
	.reg_read, .reg_rdata, .chan_in, .chan_req, .irq);
`default_nettype wire

// File: tcie_partner.sv
// Far side model: converter trigger input counting start pulses
`timescale 1ns/1ns
`default_nettype none
module tcie_partner (
	input wire logic ref_clk,
	input wire logic rst,
	input wire tcie_pkg::tcie_chan_req_t [5:0] chan_req,
	output logic [7:0] trig_cnt
);
	import tcie_pkg::*;
	// Count channel 0 start pulses
	always_ff @(posedge ref_clk) begin
		if (rst) trig_cnt <= 8'h00;
		else if (chan_req[0].conv_trigger) trig_cnt <= trig_cnt + 8'h01;
	end
endmodule
`default_nettype wire

// File: tcie_pkg.sv
// Types shared by the channel interrupt enable block
`default_nettype none
package tcie_pkg;

	// Per-channel inputs from the counter and compare logic
	typedef struct packed {
		logic [15:0] count;
		logic count_up;
		logic phase_mode;
		logic match_d;
		logic match_c;
		logic match_b;
		logic match_a;
	} tcie_chan_in_t;

	// Per-channel request outputs
	typedef struct packed {
		logic conv_trigger;
		logic underflow_irq;
		logic overflow_irq;
		logic event_d_irq;
		logic event_c_irq;
		logic event_b_irq;
		logic event_a_irq;
	} tcie_chan_req_t;

endpackage
`default_nettype wire

// File: test_timer_channel_irq_enable.sv
// Self-checking bench of the channel interrupt enable block
`timescale 1ns/1ns
`default_nettype none
module test_timer_channel_irq_enable;
	import tcie_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [7:0] reg_rdata;
	tcie_chan_in_t [5:0] chan_in = '0;
	tcie_chan_req_t [5:0] chan_req;
	logic irq;
	logic [7:0] trig_cnt;
	int n_fail = 0;
	int total_checks = 0;
	// ====
	// Clock, design and far side
	always #4 ref_clk = ~ref_clk;
	tcie_irq_enable i_tcie_irq_enable (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_write,
		.reg_read, .reg_rdata, .chan_in, .chan_req, .irq);
	tcie_partner i_tcie_partner (.ref_clk, .rst, .chan_req, .trig_cnt);
	// ====
	// Bus and compare tasks
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge ref_clk);
		reg_write <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge ref_clk);
		reg_read <= 1'b0;
		#1 chk($sformatf("reg %h", a), exp, reg_rdata);
	endtask
	task automatic pulse_a;
		@(posedge ref_clk) chan_in[0].match_a <= 1'b1;
		@(posedge ref_clk) chan_in[0].match_a <= 1'b0;
		#1;
	endtask
	// ====
	// Scenarios
	task automatic s_regs;
		for (int c = 0; c < 6; c++) rdc(8'(c), 8'h40);
		for (int c = 0; c < 6; c++) wr(8'(c), 8'hff);
		for (int c = 0; c < 6; c++) rdc(8'(c), (c % 3 == 0) ? 8'hdf : 8'hf3);
		wr(8'h00, 8'h00);
		rdc(8'h00, 8'h40);
		rdc(8'h03, 8'hdf);
		rdc(8'h20, 8'h00);
	endtask
	task automatic s_evt_a;
		wr(8'h00, 8'h81);
		pulse_a;
		chk("trigger", 8'h01, {7'h0, chan_req[0].conv_trigger});
		chk("event a", 8'h01, {7'h0, chan_req[0].event_a_irq});
		rdc(8'h08, 8'hc1);
		wr(8'h08, 8'hfe);
		#1 chk("event a", 8'h00, {7'h0, chan_req[0].event_a_irq});
		wr(8'h00, 8'h40);
		pulse_a;
		chk("trigger", 8'h00, {7'h0, chan_req[0].conv_trigger});
		chk("event a", 8'h00, {7'h0, chan_req[0].event_a_irq});
		wr(8'h00, 8'h01);
		#1 chk("event a", 8'h01, {7'h0, chan_req[0].event_a_irq});
		chk("triggers", 8'h01, trig_cnt);
	endtask
	task automatic s_ovf;
		@(posedge ref_clk) chan_in[2].count <= 16'hffff;
		@(posedge ref_clk) chan_in[2].count <= 16'h0000;
		@(posedge ref_clk) #1 chk("overflow", 8'h01, {7'h0, chan_req[2].overflow_irq});
		wr(8'h02, 8'h00);
		#1 chk("overflow", 8'h00, {7'h0, chan_req[2].overflow_irq});
	endtask
	task automatic s_uf;
		@(posedge ref_clk);
		chan_in[0].phase_mode <= 1'b1;
		chan_in[1].phase_mode <= 1'b1;
		@(posedge ref_clk);
		chan_in[0].count <= 16'hffff;
		chan_in[1].count <= 16'hffff;
		@(posedge ref_clk) #1 chk("underflow", 8'h01, {7'h0, chan_req[1].underflow_irq});
		chk("underflow", 8'h00, {7'h0, chan_req[0].underflow_irq});
	endtask
	task automatic s_sum;
		chk("irq", 8'h00, {7'h0, irq});
		wr(8'h11, 8'h3f);
		#1 chk("irq", 8'h01, {7'h0, irq});
		rdc(8'h10, 8'h07);
		chk("irq", 8'h00, {7'h0, irq});
	endtask
	task automatic s_bcd;
		wr(8'h03, 8'h0e);
		@(posedge ref_clk);
		chan_in[3].match_b <= 1'b1;
		chan_in[3].match_c <= 1'b1;
		chan_in[3].match_d <= 1'b1;
		@(posedge ref_clk);
		chan_in[3].match_b <= 1'b0;
		chan_in[3].match_c <= 1'b0;
		chan_in[3].match_d <= 1'b0;
		#1 chk("event b", 8'h01, {7'h0, chan_req[3].event_b_irq});
		chk("event c", 8'h01, {7'h0, chan_req[3].event_c_irq});
		chk("event d", 8'h01, {7'h0, chan_req[3].event_d_irq});
		rdc(8'h0b, 8'hce);
		rdc(8'h0c, 8'h40);
		rdc(8'h09, 8'h60);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Main sequence after reset
	initial begin
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		s_regs;
		s_evt_a;
		s_ovf;
		s_uf;
		s_sum;
		s_bcd;
		wrap_up;
	end
	// Watchdog
	initial begin
		repeat (2000) @(posedge ref_clk);
		n_fail++;
		wrap_up;
	end
endmodule
`default_nettype wire
